// >>> hdl/epg_programmer.sv
// Programming controller that drives a gang of UV EPROMs through their pins
`timescale 1ns/1ps
`include "epg_defines.svh"

module epg_programmer #(
  parameter int PW_CYC = `EPG_PW_CYC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Command request
  input  wire logic                  cmd_valid,
  output      logic                  cmd_ready,
  input  wire epg_pkg::epg_cmd_t     cmd,
  // Answer
  output      logic                  rsp_valid,
  output      epg_pkg::epg_rsp_t     rsp,
  // Device pins
  output      logic [`EPG_AW-1:0]    address,
  output      logic [`EPG_DW-1:0]    data_o,
  output      logic                  data_oe,
  input  wire logic [`EPG_DW-1:0]    data_i,
  output      logic [`EPG_NDEV-1:0]  program_pulse_n,
  output      logic                  gate_n,
  output      logic                  address_bit_nine_hv,
  output      logic                  vcc_en,
  output      logic                  vpp_en
);

  localparam logic [`EPG_TW-1:0] SETUP_T = `EPG_TW'(`EPG_SETUP_CYC);
  localparam logic [`EPG_TW-1:0] VPS_T   = `EPG_TW'(`EPG_VPS_CYC);
  localparam logic [`EPG_TW-1:0] OE_T    = `EPG_TW'(`EPG_OE_CYC);
  localparam logic [`EPG_TW-1:0] DFP_T   = `EPG_TW'(`EPG_DFP_CYC);
  // The timer runs down to zero inclusive, so a load of one less gives exact widths
  localparam logic [`EPG_TW-1:0] PW_T    = `EPG_TW'(PW_CYC - 1);
  localparam logic [4:0]         MAX_T   = 5'(`EPG_MAX_TRIES);

  epg_pkg::epg_state_t state_r, state_nxt;
  epg_pkg::epg_cmd_t   cmd_r;
  epg_pkg::epg_rsp_t   rsp_r;
  logic [`EPG_TW-1:0]  tmr_r, tmr_nxt;
  logic [4:0]          tries_r, tries_nxt;
  logic [6:0]          left_r, left_nxt;
  logic                over_r, over_nxt;
  logic                vcc_r, vcc_nxt;
  logic                vpp_r, vpp_nxt;
  logic [`EPG_DW-1:0]  rd_r;

  wire logic tmr_done  = (tmr_r == '0);
  wire logic is_prog   = (cmd_r.op == epg_pkg::EPG_OP_PROG);
  wire logic is_sig    = (cmd_r.op == epg_pkg::EPG_OP_SIG);
  // Supply raised for program and verify; signature reads need only the normal supply
  wire logic need_vpp  = !is_sig;
  wire logic matched   = (rd_r == cmd_r.data);
  // A wanted one that reads as zero can never be fixed by more pulses
  wire logic stuck     = |(cmd_r.data & ~rd_r);
  wire logic [6:0] over_cnt = 7'(tries_r) * 7'(`EPG_OVER_FACTOR);

  assign cmd_ready = (state_r == epg_pkg::EPG_IDLE);

  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt   = tmr_done ? tmr_r : tmr_r - `EPG_TW'(1);
    tries_nxt = tries_r;
    left_nxt  = left_r;
    over_nxt  = over_r;
    vcc_nxt   = vcc_r;
    vpp_nxt   = vpp_r;
    case (state_r)
      epg_pkg::EPG_IDLE:
      begin
        tries_nxt = 5'h0;
        over_nxt  = 1'b0;
        if (cmd_valid)
        begin
          state_nxt = (cmd.op == epg_pkg::EPG_OP_OFF) ? epg_pkg::EPG_OFFP : epg_pkg::EPG_PWR;
          tmr_nxt   = '0;
        end
      end
      epg_pkg::EPG_PWR:
      begin
        if (tmr_done)
        begin
          if (!vcc_r)
          begin
            vcc_nxt = 1'b1;
            tmr_nxt = SETUP_T;
          end
          else if (need_vpp && !vpp_r)
          begin
            vpp_nxt = 1'b1;
            tmr_nxt = VPS_T;
          end
          else
          begin
            state_nxt = epg_pkg::EPG_SETUP;
            tmr_nxt   = SETUP_T;
          end
        end
      end
      epg_pkg::EPG_SETUP:
      begin
        if (tmr_done)
        begin
          if (is_prog)
          begin
            state_nxt = epg_pkg::EPG_PULSE;
            tmr_nxt   = PW_T;
            // The overprogram run keeps its own length and try count
            left_nxt  = over_r ? left_r : 7'h1;
            tries_nxt = over_r ? tries_r : tries_r + 5'h1;
          end
          else
          begin
            state_nxt = epg_pkg::EPG_OEW;
            tmr_nxt   = OE_T;
          end
        end
      end
      epg_pkg::EPG_PULSE:
      begin
        if (tmr_done)
        begin
          // Overprogram is a run of back-to-back initial widths
          if (left_r > 7'h1)
          begin
            left_nxt = left_r - 7'h1;
            tmr_nxt  = PW_T;
          end
          else
          begin
            state_nxt = epg_pkg::EPG_HOLD;
            tmr_nxt   = SETUP_T;
          end
        end
      end
      epg_pkg::EPG_HOLD:
      begin
        if (tmr_done)
        begin
          state_nxt = over_r ? epg_pkg::EPG_DONE : epg_pkg::EPG_OEW;
          tmr_nxt   = OE_T;
        end
      end
      epg_pkg::EPG_OEW:
      begin
        if (tmr_done)
        begin
          state_nxt = epg_pkg::EPG_SAMP;
        end
      end
      epg_pkg::EPG_SAMP:
      begin
        state_nxt = epg_pkg::EPG_FLOAT;
        tmr_nxt   = DFP_T;
      end
      epg_pkg::EPG_FLOAT:
      begin
        if (tmr_done)
        begin
          if (!is_prog || stuck || (!matched && tries_r == MAX_T))
          begin
            state_nxt = epg_pkg::EPG_DONE;
          end
          else if (matched)
          begin
            state_nxt = epg_pkg::EPG_OVER;
          end
          else
          begin
            state_nxt = epg_pkg::EPG_SETUP;
            tmr_nxt   = SETUP_T;
          end
        end
      end
      epg_pkg::EPG_OVER:
      begin
        // Back through set-up so the data settles before the long pulse
        state_nxt = epg_pkg::EPG_SETUP;
        over_nxt  = 1'b1;
        left_nxt  = over_cnt;
        tmr_nxt   = SETUP_T;
      end
      epg_pkg::EPG_OFFP:
      begin
        vpp_nxt   = 1'b0;
        state_nxt = epg_pkg::EPG_OFFC;
        tmr_nxt   = VPS_T;
      end
      epg_pkg::EPG_OFFC:
      begin
        if (tmr_done)
        begin
          vcc_nxt   = 1'b0;
          state_nxt = epg_pkg::EPG_DONE;
        end
      end
      epg_pkg::EPG_DONE:
      begin
        state_nxt = epg_pkg::EPG_IDLE;
      end
      default:
      begin
        state_nxt = epg_pkg::EPG_IDLE;
      end
    endcase
  end

  // Pin levels decoded from the next state, so every pin leaves a flop
  wire logic drv_data  = (state_nxt == epg_pkg::EPG_SETUP || state_nxt == epg_pkg::EPG_PULSE ||
                          state_nxt == epg_pkg::EPG_HOLD) && is_prog;
  wire logic rd_phase  = (state_nxt == epg_pkg::EPG_OEW || state_nxt == epg_pkg::EPG_SAMP);
  wire logic sel_pulse = (state_nxt == epg_pkg::EPG_PULSE);
  // Signature read needs select and gate both low; verify keeps select high
  wire logic sel_read  = rd_phase && is_sig;
  // Stored command is stale on the taking edge, so idle never raises the level
  wire logic sig_on    = is_sig && (state_r != epg_pkg::EPG_IDLE) &&
                         !(state_nxt == epg_pkg::EPG_IDLE || state_nxt == epg_pkg::EPG_DONE);

  genvar g;
  generate
    for (g = 0; g < `EPG_NDEV; g++)
    begin : g_sel
      // Unmasked devices keep select high and are inhibited
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          program_pulse_n[g] <= 1'b1;
        else
          program_pulse_n[g] <= !(cmd_r.dev_mask[g] && (sel_pulse || sel_read));
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= epg_pkg::EPG_IDLE;
      tmr_r   <= '0;
      tries_r <= 5'h0;
      left_r  <= 7'h0;
      over_r  <= 1'b0;
      vcc_r   <= 1'b0;
      vpp_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
      tries_r <= tries_nxt;
      left_r  <= left_nxt;
      over_r  <= over_nxt;
      vcc_r   <= vcc_nxt;
      vpp_r   <= vpp_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_r               <= '0;
      rd_r                <= '0;
      data_oe             <= 1'b0;
      gate_n              <= 1'b1;
      address_bit_nine_hv <= 1'b0;
    end
    else
    begin
      if (cmd_valid && cmd_ready)
        cmd_r <= cmd;
      if (state_r == epg_pkg::EPG_SAMP)
        rd_r <= data_i;
      data_oe             <= drv_data;
      gate_n              <= !rd_phase;
      address_bit_nine_hv <= sig_on;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_r     <= '0;
      rsp_valid <= 1'b0;
    end
    else
    begin
      rsp_valid <= (state_nxt == epg_pkg::EPG_DONE);
      if (state_nxt == epg_pkg::EPG_DONE)
      begin
        rsp_r.data  <= rd_r;
        rsp_r.ok    <= (cmd_r.op != epg_pkg::EPG_OP_PROG) || over_r || (state_r == epg_pkg::EPG_HOLD);
        rsp_r.tries <= tries_r;
      end
    end
  end

  assign rsp     = rsp_r;
  assign address = cmd_r.addr;
  assign data_o  = cmd_r.data;
  assign vcc_en  = vcc_r;
  assign vpp_en  = vpp_r;

endmodule // epg_programmer

// >>> common/epg_defines.svh
// Timing counts and limits for the EPROM programming controller
`ifndef EPG_DEFINES_SVH
`define EPG_DEFINES_SVH

`define EPG_CLK_NS        100
`define EPG_T_SETUP_NS    2000
`define EPG_T_OE_NS       150
`define EPG_T_DFP_NS      130
`define EPG_T_PW_NS       1000000
`define EPG_T_VPS_NS      2000
// Least times round up to whole cycles
`define EPG_SETUP_CYC     ((`EPG_T_SETUP_NS + `EPG_CLK_NS - 1) / `EPG_CLK_NS)
`define EPG_VPS_CYC       ((`EPG_T_VPS_NS + `EPG_CLK_NS - 1) / `EPG_CLK_NS)
`define EPG_OE_CYC        ((`EPG_T_OE_NS + `EPG_CLK_NS - 1) / `EPG_CLK_NS)
`define EPG_DFP_CYC       ((`EPG_T_DFP_NS + `EPG_CLK_NS - 1) / `EPG_CLK_NS)
`define EPG_PW_CYC        ((`EPG_T_PW_NS + `EPG_CLK_NS - 1) / `EPG_CLK_NS)
`define EPG_MAX_TRIES     25
`define EPG_OVER_FACTOR   3
`define EPG_NDEV          2
`define EPG_AW            15
`define EPG_DW            8
`define EPG_TW            20

`endif

// >>> common/epg_pkg.sv
// Types for the EPROM programming controller
`include "epg_defines.svh"

package epg_pkg;

  typedef enum logic [1:0]
  {
    EPG_OP_PROG = 2'h0,
    EPG_OP_READ = 2'h1,
    EPG_OP_SIG  = 2'h2,
    EPG_OP_OFF  = 2'h3
  } epg_op_t;

  typedef struct packed
  {
    epg_op_t                  op;
    logic [`EPG_NDEV-1:0]     dev_mask;
    logic [`EPG_AW-1:0]       addr;
    logic [`EPG_DW-1:0]       data;
  } epg_cmd_t;

  typedef struct packed
  {
    logic [`EPG_DW-1:0]       data;
    logic                     ok;
    logic [4:0]               tries;
  } epg_rsp_t;

  typedef enum logic [11:0]
  {
    EPG_IDLE  = 12'h001,
    EPG_PWR   = 12'h002,
    EPG_SETUP = 12'h004,
    EPG_PULSE = 12'h008,
    EPG_HOLD  = 12'h010,
    EPG_OEW   = 12'h020,
    EPG_SAMP  = 12'h040,
    EPG_FLOAT = 12'h080,
    EPG_OFFP  = 12'h100,
    EPG_OFFC  = 12'h200,
    EPG_DONE  = 12'h400,
    EPG_OVER  = 12'h800
  } epg_state_t;

endpackage

// >>> verification/epg_programmer_properties.sv
// Pin-level checker for the EPROM programming controller
`timescale 1ns/1ps
`include "epg_defines.svh"
module epg_prog_chk #(
  parameter int PW_CYC = 5
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // Command side
  input wire logic                 cmd_valid,
  input wire logic                 cmd_ready,
  input wire epg_pkg::epg_cmd_t    cmd,
  input wire logic                 rsp_valid,
  input wire epg_pkg::epg_rsp_t    rsp,
  // Device pins
  input wire logic [`EPG_AW-1:0]   address,
  input wire logic [`EPG_DW-1:0]   data_o,
  input wire logic                 data_oe,
  input wire logic [`EPG_DW-1:0]   data_i,
  input wire logic [`EPG_NDEV-1:0] program_pulse_n,
  input wire logic                 gate_n,
  input wire logic                 address_bit_nine_hv,
  input wire logic                 vcc_en,
  input wire logic                 vpp_en
);
  logic                 sel_lo;
  logic                 rd_r;
  int                   low_r;
  logic [`EPG_NDEV-1:0] mask_r;
  assign sel_lo = ~&program_pulse_n;
  // Signature reads also lower select, so they are kept out of the width count
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      low_r  <= 0;
      rd_r   <= 1'b0;
      mask_r <= '0;
    end
    else
    begin
      low_r  <= sel_lo ? low_r + 1 : 0;
      rd_r   <= sel_lo & (rd_r | !gate_n | address_bit_nine_hv);
      mask_r <= (cmd_valid && cmd_ready) ? cmd.dev_mask : mask_r;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_vcc_before_vpp: assert property (vpp_en |-> vcc_en)
    else $error("programming supply up without normal supply");
  chk_vcc_after_vpp: assert property ($fell(vcc_en) |-> !vpp_en && !$past(vpp_en))
    else $error("normal supply removed before programming supply");
  chk_data_in_pulse: assert property (sel_lo && gate_n && vpp_en |-> data_oe)
    else $error("program pulse without data driven");
  chk_no_contention: assert property (!gate_n |-> !data_oe)
    else $error("controller drives data while gate is low");
  chk_verify_levels: assert property (!gate_n && !address_bit_nine_hv |-> !sel_lo && vpp_en)
    else $error("verify read with wrong select or supply");
  chk_data_stable: assert property (data_oe && $past(data_oe) |-> $stable(data_o) && $stable(address))
    else $error("data or address moved while driven");
  chk_pulse_min: assert property ($fell(sel_lo) && !rd_r && vpp_en |-> low_r * 100 >= PW_CYC * 95)
    else $error("program pulse too short");
  chk_pulse_max: assert property ($fell(sel_lo) && !rd_r && vpp_en |-> low_r * 100 <= PW_CYC * 7875)
    else $error("program pulse too long");
  chk_pulse_band: assert property ($fell(sel_lo) && !rd_r && vpp_en |->
      low_r * 100 <= PW_CYC * 105 || low_r * 100 >= PW_CYC * 285)
    else $error("program pulse between initial and overprogram widths");
  chk_mask_only: assert property (!cmd_ready |-> (~program_pulse_n & ~mask_r) == '0)
    else $error("select lowered on an unmasked device");
  chk_hv_levels: assert property (address_bit_nine_hv |-> vcc_en && !data_oe)
    else $error("elevated address level without read set-up");
endmodule // epg_prog_chk

bind epg_programmer epg_prog_chk #(.PW_CYC(PW_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .rsp_valid(rsp_valid), .rsp(rsp), .address(address), .data_o(data_o), .data_oe(data_oe),
  .data_i(data_i), .program_pulse_n(program_pulse_n), .gate_n(gate_n),
  .address_bit_nine_hv(address_bit_nine_hv), .vcc_en(vcc_en), .vpp_en(vpp_en));

// >>> verification/epg_eprom_model.sv
// Behavioural model of one UV EPROM on the programmer's pins
`timescale 1ns/1ps
`include "epg_defines.svh"
module epg_eprom_model #(
  parameter logic [7:0] SIG_MAKER = 8'h3c, // Arbitrary value
  parameter logic [7:0] SIG_PART  = 8'hc3  // Arbitrary value
) (
  // Pins
  input wire logic [`EPG_AW-1:0] address,
  input wire logic [`EPG_DW-1:0] d,
  input wire logic               sel_n,
  input wire logic               gate_n,
  input wire logic               hv,
  input wire logic               vcc,
  input wire logic               vpp,
  // Pulses needed before the cells take
  input wire logic [7:0]         slow,
  // Data out
  output logic [`EPG_DW-1:0]     q,
  output logic                   q_oe
);
  logic [`EPG_DW-1:0] mem [0:(1<<`EPG_AW)-1];
  logic [`EPG_AW-1:0] last_a;
  int                 cnt;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    cnt = 0;
    last_a = '0;
  end
  // End of a select pulse in program mode; gate high keeps reads out
  always @(posedge sel_n)
    if (vcc && vpp && gate_n && !hv)
    begin
      cnt = (address == last_a) ? cnt + 1 : 1;
      last_a = address;
      if (cnt >= slow)
        mem[address] = mem[address] & d;
    end
  assign q_oe = vcc && !gate_n && (!sel_n || vpp);
  assign q = (hv && !sel_n) ? (address[0] ? SIG_PART : SIG_MAKER) : mem[address];
endmodule // epg_eprom_model

// >>> verification/epg_programmer_tb.sv
// Self-checking bench for the EPROM programming controller
`timescale 1ns/1ps
`include "epg_defines.svh"
module epg_programmer_tb;
  localparam int PW = 5;
  logic                 clk;
  logic                 rst_n;
  logic                 cmd_valid;
  logic                 cmd_ready;
  epg_pkg::epg_cmd_t    cmd;
  logic                 rsp_valid;
  epg_pkg::epg_rsp_t    rsp;
  epg_pkg::epg_rsp_t    r;
  logic [`EPG_AW-1:0]   address;
  logic [`EPG_DW-1:0]   data_o;
  logic                 data_oe;
  logic [`EPG_DW-1:0]   data_i;
  logic [`EPG_NDEV-1:0] sel_n;
  logic                 gate_n;
  logic                 hv;
  logic                 vcc_en;
  logic                 vpp_en;
  logic [7:0]           q0, q1, last_r, slow;
  logic                 oe0, oe1;
  int                   fail_count, check_count, cyc;

  // Both parts answering: low bits win; released bus keeps changing
  assign data_i = data_oe ? data_o : (oe0 || oe1) ? ((oe0 ? q0 : 8'hff) & (oe1 ? q1 : 8'hff)) : ~last_r;

  epg_programmer #(.PW_CYC(PW)) dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .address(address), .data_o(data_o), .data_oe(data_oe),
    .data_i(data_i), .program_pulse_n(sel_n), .gate_n(gate_n), .address_bit_nine_hv(hv), .vcc_en(vcc_en),
    .vpp_en(vpp_en));
  epg_eprom_model dev0 (.address(address), .d(data_i), .sel_n(sel_n[0]), .gate_n(gate_n), .hv(hv),
    .vcc(vcc_en), .vpp(vpp_en), .slow(slow), .q(q0), .q_oe(oe0));
  epg_eprom_model dev1 (.address(address), .d(data_i), .sel_n(sel_n[1]), .gate_n(gate_n), .hv(hv),
    .vcc(vcc_en), .vpp(vpp_en), .slow(slow), .q(q1), .q_oe(oe1));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One command: request held until taken, answer caught in its one cycle
  task automatic run(input epg_pkg::epg_op_t op, input logic [1:0] m, input logic [14:0] a, input logic [7:0] d);
    logic rdy;
    cmd_valid <= 1'b1;
    cmd <= '{op, m, a, d};
    do
    begin
      @(negedge clk);
      rdy = cmd_ready;
      @(posedge clk);
    end while (rdy !== 1'b1);
    cmd_valid <= 1'b0;
    do
      @(negedge clk);
    while (rsp_valid !== 1'b1);
    r = rsp;
    @(posedge clk);
  endtask

  task automatic t_reset;
    @(negedge clk);
    check("ready", cmd_ready, 1'b1);
    check("select", sel_n, 2'b11);
    check("pins", {gate_n, data_oe, vcc_en, vpp_en}, 4'h8);
  endtask

  task automatic t_sig;
    run(epg_pkg::EPG_OP_SIG, 2'b01, 15'h0000, 8'h00);
    check("maker", r.data, 8'h3c);
    run(epg_pkg::EPG_OP_SIG, 2'b01, 15'h0001, 8'h00);
    check("part", r.data, 8'hc3);
    check("supply", {vcc_en, vpp_en}, 2'b10);
    run(epg_pkg::EPG_OP_READ, 2'b01, 15'h7fff, 8'h00);
    check("erased", r.data, 8'hff);
  endtask

  task automatic t_prog;
    run(epg_pkg::EPG_OP_PROG, 2'b01, 15'h0123, 8'h5a);
    check("ok", {r.ok, r.tries}, 6'h21);
    check("dev1 kept", dev1.mem[15'h0123], 8'hff);
    run(epg_pkg::EPG_OP_READ, 2'b01, 15'h0123, 8'h00);
    check("verify", r.data, 8'h5a);
    run(epg_pkg::EPG_OP_PROG, 2'b01, 15'h0123, 8'hff);
    check("restore", r.ok, 1'b0);
    check("cells", dev0.mem[15'h0123], 8'h5a);
  endtask

  task automatic t_inhibit;
    run(epg_pkg::EPG_OP_PROG, 2'b10, 15'h0200, 8'h00);
    check("dev0 inhibited", dev0.mem[15'h0200], 8'hff);
    check("dev1 written", dev1.mem[15'h0200], 8'h00);
  endtask

  task automatic t_slow;
    slow <= 8'h03;
    run(epg_pkg::EPG_OP_PROG, 2'b11, 15'h0456, 8'h0f);
    check("three tries", {r.ok, r.tries}, 6'h23);
    check("gang", {dev0.mem[15'h0456], dev1.mem[15'h0456]}, 16'h0f0f);
    slow <= 8'h1e;
    run(epg_pkg::EPG_OP_PROG, 2'b01, 15'h0300, 8'h01);
    check("give up", {r.ok, r.tries}, 6'h19);
    slow <= 8'h01;
    run(epg_pkg::EPG_OP_OFF, 2'b01, 15'h0000, 8'h00);
    @(negedge clk);
    check("off", {vcc_en, vpp_en}, 2'b00);
  endtask

  always @(posedge clk)
  begin
    last_r <= data_i;
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out;
    end
  end

  initial
  begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    slow = 8'h01;
    last_r = 8'h00;
    t_reset;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_sig;
    t_prog;
    t_inhibit;
    t_slow;
    close_out;
  end
endmodule // epg_programmer_tb
